// ===== rtl/pio_pkg.sv
// constants for the parallel port block: register indices, fields, resets
// assumes a 32-bit avalon-mm slave where each register takes one word
package pio_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam int unsigned FIRST_PORT_DATA_IDX = 8'h00;
  localparam int unsigned SECOND_PORT_DATA_IDX = 8'h01;
  localparam int unsigned FIRST_PORT_DIRECTION_IDX = 8'h04;
  localparam int unsigned SECOND_PORT_DIRECTION_IDX = 8'h05;
  localparam int unsigned PULLDOWN_INHIBIT_A_C_IDX = 8'h10;
  localparam int unsigned OPTION_REGISTER_IDX = 8'h1F;

  // ----------------------------------------------------------------------
  // widths and fields
  // ----------------------------------------------------------------------
  localparam int unsigned FIRST_PORT_W = 6;
  localparam int unsigned SECOND_PORT_W = 8;
  localparam int unsigned THIRD_PORT_W = 8;
  localparam int unsigned PORT_IRQ_PINS = 4;
  localparam int unsigned LOWER_C_PULL_INHIBIT_BIT = 6;
  localparam int unsigned UPPER_C_PULL_INHIBIT_BIT = 7;
  localparam int unsigned GLOBAL_PULLDOWN_DISABLE_BIT = 0;
  localparam int unsigned PORT_INTERRUPT_OPTION_BIT = 1;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [5:0] FIRST_PORT_DIRECTION_RST = 6'h00;
  localparam logic [7:0] SECOND_PORT_DIRECTION_RST = 8'h00;
  localparam logic [7:0] PULLDOWN_INHIBIT_A_C_RST = 8'h00;
  localparam logic [1:0] OPTION_REGISTER_RST = 2'h0;

  // bus answer state
  typedef enum logic {PIO_IDLE, PIO_ANSWER} pio_bus_state_t;

endpackage : pio_pkg

// ===== rtl/pio_ports.sv
// parallel i/o ports a and b with pull-down control and port a interrupts
// assumes an avalon-mm master on clk; pins arrive asynchronously and the
// pad ring resolves the wire from out and the active-low output enable
//
// Summary of operation
// - output pin drives first port latch bit, or-ed with the comparator on pa5-pa4
// - read gives latch if output, pin if input
// - six port a bits, upper two read zero
// - reset leaves port a latch untouched
// - latch writes land in any direction when byte lane 0 is enabled
// - direction one drives pin, kills pull-down
// - reset clears port a directions, blocks comparators
// - upper two direction bits read zero
// - pull-down inhibit register is write only
// - inhibit zero gives pull-down on inputs only
// - global disable turns all pull-downs off
// - two inhibit bits steer port c nibbles
// - reset clears inhibit register, pull-downs on
// - option bit makes pa3-pa0 interrupt sources
// - port a interrupt active high or rising
// - option bit picks edge or edge-and-level
// - port b eight pins, latch survives reset
// - port b read gives pin on inputs
// - port b direction register sets each pin
// - reset clears port b directions
`timescale 1ns/1ps

module pio_ports #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DATA_IDX_A = pio_pkg::FIRST_PORT_DATA_IDX,
  parameter int unsigned DATA_IDX_B = pio_pkg::SECOND_PORT_DATA_IDX,
  parameter int unsigned DIR_IDX_A = pio_pkg::FIRST_PORT_DIRECTION_IDX,
  parameter int unsigned DIR_IDX_B = pio_pkg::SECOND_PORT_DIRECTION_IDX,
  parameter int unsigned PULL_IDX = pio_pkg::PULLDOWN_INHIBIT_A_C_IDX,
  parameter int unsigned OPT_IDX = pio_pkg::OPTION_REGISTER_IDX
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [pio_pkg::FIRST_PORT_W-1:0] first_port_bits_in,
  output logic [pio_pkg::FIRST_PORT_W-1:0] first_port_bits_out,
  output logic [pio_pkg::FIRST_PORT_W-1:0] first_port_bits_oe_n,
  output logic [pio_pkg::FIRST_PORT_W-1:0] first_port_pulldown_en,
  input wire logic [pio_pkg::SECOND_PORT_W-1:0] second_port_bits_in,
  output logic [pio_pkg::SECOND_PORT_W-1:0] second_port_bits_out,
  output logic [pio_pkg::SECOND_PORT_W-1:0] second_port_bits_oe_n,
  input wire logic [pio_pkg::THIRD_PORT_W-1:0] third_port_direction,
  output logic [pio_pkg::THIRD_PORT_W-1:0] third_port_pulldown_en,
  input wire logic [1:0] comparator_drive_en,
  input wire logic [1:0] comparator_level,
  input wire logic ext_irq_pin_n,
  output logic ext_irq_request
);

  localparam int unsigned IDX_W = ADDR_W - 2;
  localparam int unsigned PA_W = pio_pkg::FIRST_PORT_W;
  localparam int unsigned PB_W = pio_pkg::SECOND_PORT_W;
  localparam int unsigned NIRQ = pio_pkg::PORT_IRQ_PINS;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  initial begin
    if (ADDR_W < 3 || ADDR_W > 32)
      $error("pio_ports: ADDR_W out of range");
    if (PA_W > 8 || PB_W > 8)
      $error("pio_ports: a port is wider than one byte");
    if (pio_pkg::THIRD_PORT_W != 8)
      $error("pio_ports: port c must have two nibbles");
    if (NIRQ > PA_W)
      $error("pio_ports: more interrupt pins than port a bits");
    if (pio_pkg::LOWER_C_PULL_INHIBIT_BIT < PA_W)
      $error("pio_ports: lower port c inhibit overlaps port a");
    if (pio_pkg::UPPER_C_PULL_INHIBIT_BIT < PA_W)
      $error("pio_ports: upper port c inhibit overlaps port a");
    if (pio_pkg::GLOBAL_PULLDOWN_DISABLE_BIT > 1)
      $error("pio_ports: global disable bit outside option");
    if (pio_pkg::PORT_INTERRUPT_OPTION_BIT > 1)
      $error("pio_ports: interrupt option bit outside option");
    if ((DATA_IDX_A >> IDX_W) != 0)
      $error("pio_ports: DATA_IDX_A beyond address width");
    if ((DATA_IDX_B >> IDX_W) != 0)
      $error("pio_ports: DATA_IDX_B beyond address width");
    if ((DIR_IDX_A >> IDX_W) != 0)
      $error("pio_ports: DIR_IDX_A beyond address width");
    if ((DIR_IDX_B >> IDX_W) != 0)
      $error("pio_ports: DIR_IDX_B beyond address width");
    if ((PULL_IDX >> IDX_W) != 0)
      $error("pio_ports: PULL_IDX beyond address width");
    if ((OPT_IDX >> IDX_W) != 0)
      $error("pio_ports: OPT_IDX beyond address width");
    if (DATA_IDX_A == DATA_IDX_B)
      $error("pio_ports: DATA_IDX_A equals DATA_IDX_B");
    if (DATA_IDX_A == DIR_IDX_A)
      $error("pio_ports: DATA_IDX_A equals DIR_IDX_A");
    if (DATA_IDX_A == DIR_IDX_B)
      $error("pio_ports: DATA_IDX_A equals DIR_IDX_B");
    if (DATA_IDX_A == PULL_IDX)
      $error("pio_ports: DATA_IDX_A equals PULL_IDX");
    if (DATA_IDX_A == OPT_IDX)
      $error("pio_ports: DATA_IDX_A equals OPT_IDX");
    if (DATA_IDX_B == DIR_IDX_A)
      $error("pio_ports: DATA_IDX_B equals DIR_IDX_A");
    if (DATA_IDX_B == DIR_IDX_B)
      $error("pio_ports: DATA_IDX_B equals DIR_IDX_B");
    if (DATA_IDX_B == PULL_IDX)
      $error("pio_ports: DATA_IDX_B equals PULL_IDX");
    if (DATA_IDX_B == OPT_IDX)
      $error("pio_ports: DATA_IDX_B equals OPT_IDX");
    if (DIR_IDX_A == DIR_IDX_B)
      $error("pio_ports: DIR_IDX_A equals DIR_IDX_B");
    if (DIR_IDX_A == PULL_IDX)
      $error("pio_ports: DIR_IDX_A equals PULL_IDX");
    if (DIR_IDX_A == OPT_IDX)
      $error("pio_ports: DIR_IDX_A equals OPT_IDX");
    if (DIR_IDX_B == PULL_IDX)
      $error("pio_ports: DIR_IDX_B equals PULL_IDX");
    if (DIR_IDX_B == OPT_IDX)
      $error("pio_ports: DIR_IDX_B equals OPT_IDX");
    if (PULL_IDX == OPT_IDX)
      $error("pio_ports: PULL_IDX equals OPT_IDX");
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [PA_W-1:0] pa_meta, pa_sync;
  logic [PB_W-1:0] pb_meta, pb_sync;
  logic irq_meta, irq_sync;
  logic [PA_W-1:0] next_pa_meta, next_pa_sync;
  logic [PB_W-1:0] next_pb_meta, next_pb_sync;
  logic next_irq_meta, next_irq_sync;

  // only the second flop feeds logic; the first may still be settling
  always_comb begin
    next_pa_meta = first_port_bits_in;
    next_pa_sync = pa_meta;
    next_pb_meta = second_port_bits_in;
    next_pb_sync = pb_meta;
    next_irq_meta = ext_irq_pin_n;
    next_irq_sync = irq_meta;
  end

  // the interrupt pin idles high, so reset to one avoids a false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_meta <= '0;
      pa_sync <= '0;
      pb_meta <= '0;
      pb_sync <= '0;
      irq_meta <= 1'b1;
      irq_sync <= 1'b1;
    end else begin
      pa_meta <= next_pa_meta;
      pa_sync <= next_pa_sync;
      pb_meta <= next_pb_meta;
      pb_sync <= next_pb_sync;
      irq_meta <= next_irq_meta;
      irq_sync <= next_irq_sync;
    end
  end

  // ----------------------------------------------------------------------
  // bus decode and answer
  // ----------------------------------------------------------------------
  pio_pkg::pio_bus_state_t bus_state, next_bus_state;
  logic [31:0] next_avs_readdata;
  logic [IDX_W-1:0] idx;
  logic wr_take, rd_take;

  // every access answers on the cycle after it is raised
  assign idx = avs_address[ADDR_W-1:2];
  assign avs_waitrequest = (avs_read | avs_write) &
                           (bus_state == pio_pkg::PIO_IDLE);
  assign wr_take = avs_write & (bus_state == pio_pkg::PIO_ANSWER) &
                   avs_byteenable[0];

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [PA_W-1:0] pa_latch, next_pa_latch;
  logic [PB_W-1:0] pb_latch, next_pb_latch;
  logic [PA_W-1:0] pa_dir, next_pa_dir;
  logic [PB_W-1:0] pb_dir, next_pb_dir;
  logic [7:0] pull_inh, next_pull_inh;
  logic [1:0] option, next_option;

  always_comb begin
    next_pa_latch = pa_latch;
    next_pb_latch = pb_latch;
    next_pa_dir = pa_dir;
    next_pb_dir = pb_dir;
    next_pull_inh = pull_inh;
    next_option = option;
    if (wr_take) begin
      case (idx)
        IDX_W'(DATA_IDX_A): next_pa_latch = avs_writedata[PA_W-1:0];
        IDX_W'(DATA_IDX_B): next_pb_latch = avs_writedata[PB_W-1:0];
        IDX_W'(DIR_IDX_A): next_pa_dir = avs_writedata[PA_W-1:0];
        IDX_W'(DIR_IDX_B): next_pb_dir = avs_writedata[PB_W-1:0];
        IDX_W'(PULL_IDX): next_pull_inh = avs_writedata[7:0];
        IDX_W'(OPT_IDX): next_option = avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  // data latches hold their value through reset, so no reset branch
  always_ff @(posedge clk) begin
    pa_latch <= next_pa_latch;
    pb_latch <= next_pb_latch;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_dir <= pio_pkg::FIRST_PORT_DIRECTION_RST;
      pb_dir <= pio_pkg::SECOND_PORT_DIRECTION_RST;
      pull_inh <= pio_pkg::PULLDOWN_INHIBIT_A_C_RST;
      option <= pio_pkg::OPTION_REGISTER_RST;
    end else begin
      pa_dir <= next_pa_dir;
      pb_dir <= next_pb_dir;
      pull_inh <= next_pull_inh;
      option <= next_option;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [PA_W-1:0] pa_view;
  logic [PB_W-1:0] pb_view;

  genvar gi;

  // an output reads its latch, an input its synchronised pin
  generate
    for (gi = 0; gi < PA_W; gi++) begin : g_pa_view
      assign pa_view[gi] = pa_dir[gi] ? pa_latch[gi] : pa_sync[gi];
    end
    for (gi = 0; gi < PB_W; gi++) begin : g_pb_view
      assign pb_view[gi] = pb_dir[gi] ? pb_latch[gi] : pb_sync[gi];
    end
  endgenerate
  assign rd_take = avs_read & (bus_state == pio_pkg::PIO_IDLE);

  always_comb begin
    next_bus_state = pio_pkg::PIO_IDLE;
    next_avs_readdata = avs_readdata;
    case (bus_state)
      pio_pkg::PIO_IDLE: begin
        if (avs_read | avs_write)
          next_bus_state = pio_pkg::PIO_ANSWER;
      end
      pio_pkg::PIO_ANSWER: next_bus_state = pio_pkg::PIO_IDLE;
      default: next_bus_state = pio_pkg::PIO_IDLE;
    endcase
    if (rd_take) begin
      // upper bits are zero-filled; the inhibit register reads as zero
      // because it is write only and software must not rely on it
      case (idx)
        IDX_W'(DATA_IDX_A): next_avs_readdata = {26'h0, pa_view};
        IDX_W'(DATA_IDX_B): next_avs_readdata = {24'h0, pb_view};
        IDX_W'(DIR_IDX_A): next_avs_readdata = {26'h0, pa_dir};
        IDX_W'(DIR_IDX_B): next_avs_readdata = {24'h0, pb_dir};
        IDX_W'(PULL_IDX): next_avs_readdata = 32'h0;
        IDX_W'(OPT_IDX): next_avs_readdata = {30'h0, option};
        default: next_avs_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= pio_pkg::PIO_IDLE;
      avs_readdata <= 32'h0;
    end else begin
      bus_state <= next_bus_state;
      avs_readdata <= next_avs_readdata;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive and pull-downs
  // ----------------------------------------------------------------------
  logic gpd_off;
  logic [PA_W-1:0] cmp_or;

  assign gpd_off = option[pio_pkg::GLOBAL_PULLDOWN_DISABLE_BIT];
  // comparators only reach pa5..pa4, and only once direction is set
  assign cmp_or = {comparator_drive_en & comparator_level, 4'h0};
  generate
    for (gi = 0; gi < PA_W; gi++) begin : g_pa_pin
      assign first_port_bits_out[gi] =
        pa_latch[gi] | cmp_or[gi];
      assign first_port_bits_oe_n[gi] = ~pa_dir[gi];
      // a driving pin never fights its own pull-down
      assign first_port_pulldown_en[gi] =
        ~pa_dir[gi] & ~pull_inh[gi] & ~gpd_off;
    end
    for (gi = 0; gi < PB_W; gi++) begin : g_pb_pin
      assign second_port_bits_out[gi] = pb_latch[gi];
      assign second_port_bits_oe_n[gi] = ~pb_dir[gi];
    end
    // one inhibit bit serves a whole nibble of port c
    for (gi = 0; gi < pio_pkg::THIRD_PORT_W; gi++) begin : g_pc_pull
      localparam int unsigned INH_BIT = (gi < 4) ?
        pio_pkg::LOWER_C_PULL_INHIBIT_BIT :
        pio_pkg::UPPER_C_PULL_INHIBIT_BIT;
      assign third_port_pulldown_en[gi] = ~third_port_direction[gi] &
        ~pull_inh[INH_BIT] & ~gpd_off;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // external interrupt sourcing
  // ----------------------------------------------------------------------
  logic [NIRQ-1:0] pa_prev;
  logic irq_prev, port_irq_en, next_ext_irq_request;
  logic [NIRQ-1:0] pa_rise;
  logic [NIRQ-1:0] pa_level;
  logic pin_fall, pin_low, port_active;

  assign port_irq_en = option[pio_pkg::PORT_INTERRUPT_OPTION_BIT];

  generate
    for (gi = 0; gi < NIRQ; gi++) begin : g_pa_irq
      // a high level and a rising edge both count as active
      assign pa_level[gi] = pa_sync[gi];
      assign pa_rise[gi] = pa_sync[gi] & ~pa_prev[gi];
    end
  endgenerate

  assign pin_fall = irq_prev & ~irq_sync;
  assign pin_low = ~irq_sync;
  assign port_active = (|pa_rise) | (|pa_level);

  // option clear: only the dedicated pin, falling edge only;
  // option set: port a pins join, and levels count as well as edges
  // the request is a one-cycle pulse with option clear and a level with option set; latching it is left to the interrupt logic
  always_comb begin
    next_ext_irq_request = pin_fall;
    if (port_irq_en) begin
      next_ext_irq_request = pin_low | port_active;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_prev <= '0;
      irq_prev <= 1'b1;
      ext_irq_request <= 1'b0;
    end else begin
      pa_prev <= pa_sync[NIRQ-1:0];
      irq_prev <= irq_sync;
      ext_irq_request <= next_ext_irq_request;
    end
  end

endmodule : pio_ports

// ===== verification/parallel_io_ports_a_b_bench.sv
// self-checking bench for the parallel port block
// assumes the design, its checker and the board model compile first
`timescale 1ns/1ps
module parallel_io_ports_a_b_bench;
  typedef struct packed {logic w; logic [5:0] idx; logic [7:0] d;} pio_row_t;
  localparam logic [5:0] PA = 6'(pio_pkg::FIRST_PORT_DATA_IDX);
  localparam logic [5:0] PB = 6'(pio_pkg::SECOND_PORT_DATA_IDX);
  localparam logic [5:0] DA = 6'(pio_pkg::FIRST_PORT_DIRECTION_IDX);
  localparam logic [5:0] DB = 6'(pio_pkg::SECOND_PORT_DIRECTION_IDX);
  localparam logic [5:0] PU = 6'(pio_pkg::PULLDOWN_INHIBIT_A_C_IDX);
  localparam logic [5:0] OP = 6'(pio_pkg::OPTION_REGISTER_IDX);
  localparam pio_row_t ROWS [16] = '{'{1, PA, 8'hFF}, '{0, PA, 8'h15},
    '{1, DA, 8'h0F}, '{0, DA, 8'h0F}, '{0, PA, 8'h1F}, '{1, DA, 8'hFF},
    '{0, DA, 8'h3F}, '{0, PA, 8'h3F}, '{1, PU, 8'hFF}, '{0, PU, 8'h00},
    '{1, PB, 8'h3C}, '{1, DB, 8'hF0}, '{0, PB, 8'h35}, '{0, DB, 8'hF0},
    '{1, 6'h2A, 8'h77}, '{0, 6'h2A, 8'h00}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, irq;
  logic irq_n = 1'b1;
  logic [5:0] a_out, a_oe_n, a_pd, a_pin;
  logic [5:0] a_drv = 6'h15;
  logic [7:0] b_out, b_oe_n, b_pin, c_pd;
  logic [7:0] c_dir = 8'h81;
  logic [1:0] cmp = 2'h0;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  always #12.5 clk = ~clk;
  pio_ports DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .first_port_bits_in(a_pin),
    .first_port_bits_out(a_out), .first_port_bits_oe_n(a_oe_n),
    .first_port_pulldown_en(a_pd), .second_port_bits_in(b_pin),
    .second_port_bits_out(b_out), .second_port_bits_oe_n(b_oe_n),
    .third_port_direction(c_dir), .third_port_pulldown_en(c_pd),
    .comparator_drive_en(cmp), .comparator_level(cmp),
    .ext_irq_pin_n(irq_n), .ext_irq_request(irq));
  pio_board_model board (.clk(clk), .a_out(a_out), .a_oe_n(a_oe_n),
    .a_pd(a_pd), .a_drv_en(6'h3F), .a_drv(a_drv), .a_pin(a_pin),
    .b_out(b_out), .b_oe_n(b_oe_n), .b_drv_en(8'hFF), .b_drv(8'hA5),
    .b_pin(b_pin));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // request held until waitrequest is seen low at a falling edge, then through the next rising edge
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    do @(negedge clk); while (avs_waitrequest !== 1'b0);
    @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      bus(ROWS[i].w, ROWS[i].idx, ROWS[i].d);
      if (!ROWS[i].w) chk($sformatf("row %0d", i), q, 32'(ROWS[i].d));
    end
    chk("pa out", 32'(a_out), 32'h3F);
    chk("pb out", {b_oe_n, b_out}, 32'h0F3C);
    bus(1, DA, 8'h05);
    bus(1, PU, 8'h42);
    @(negedge clk);
    chk("pulls", {c_pd, 2'h0, a_pd}, 32'h7038);
    bus(1, OP, 8'h01);
    @(negedge clk);
    chk("global off", {c_pd, 2'h0, a_pd}, 32'h0);
    @(posedge clk) rst_n <= 1'b0;
    @(negedge clk);
    chk("in reset", {c_pd, b_oe_n, 2'h0, a_oe_n, 2'h0, a_pd}, 32'h7EFF3F3F);
    @(posedge clk) rst_n <= 1'b1;
    bus(0, DA, 8'h00);
    chk("dir a reset", q, 32'h0);
    bus(0, PB, 8'h00);
    chk("pb pins", q, 32'hA5);
    bus(1, DA, 8'h3F);
    bus(0, PA, 8'h00);
    chk("latch kept", q, 32'h3F);
    bus(1, DA, 8'h00);
    @(posedge clk) irq_n <= 1'b0;
    n = 0;
    repeat (8) @(negedge clk) n += int'(irq === 1'b1);
    chk("edge pulses", n, 1);
    @(posedge clk) irq_n <= 1'b1;
    bus(1, OP, 8'h02);
    repeat (4) @(negedge clk);
    chk("level irq", irq, 1'b1);
    @(posedge clk) a_drv <= 6'h00;
    repeat (4) @(negedge clk);
    chk("irq quiet", irq, 1'b0);
    @(posedge clk) a_drv <= 6'h04;
    repeat (4) @(negedge clk);
    chk("rising irq", irq, 1'b1);
    final_report();
  end
endmodule : parallel_io_ports_a_b_bench
bind pio_ports pio_ports_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk),
  .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .first_port_bits_out(first_port_bits_out),
  .first_port_bits_oe_n(first_port_bits_oe_n),
  .first_port_pulldown_en(first_port_pulldown_en),
  .second_port_bits_out(second_port_bits_out),
  .second_port_bits_oe_n(second_port_bits_oe_n),
  .third_port_direction(third_port_direction),
  .third_port_pulldown_en(third_port_pulldown_en),
  .ext_irq_pin_n(ext_irq_pin_n), .ext_irq_request(ext_irq_request));

// ===== verification/pio_board_model.sv
// board model: resolves the port pins from device drive, board drive, pulls
// assumes device drives while oe_n is low; a floating pin wanders
`timescale 1ns/1ps
module pio_board_model (
  input wire logic clk,
  input wire logic [5:0] a_out,
  input wire logic [5:0] a_oe_n,
  input wire logic [5:0] a_pd,
  input wire logic [5:0] a_drv_en,
  input wire logic [5:0] a_drv,
  output logic [5:0] a_pin,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe_n,
  input wire logic [7:0] b_drv_en,
  input wire logic [7:0] b_drv,
  output logic [7:0] b_pin
);
  logic [5:0] a_last = 6'h00;
  logic [7:0] b_last = 8'h00;
  // device wins over the board; an undriven pin without pull toggles
  assign a_pin = (~a_oe_n & a_out) | (a_oe_n & a_drv_en & a_drv) |
    (a_oe_n & ~a_drv_en & ~a_pd & ~a_last);
  assign b_pin = (~b_oe_n & b_out) | (b_oe_n & b_drv_en & b_drv) |
    (b_oe_n & ~b_drv_en & ~b_last);
  always @(posedge clk) begin
    a_last <= a_pin;
    b_last <= b_pin;
  end
endmodule : pio_board_model

// ===== verification/pio_ports_props.sv
// assertions on the parallel port block, seen from its ports only
// assumes one clock domain and async active-low reset; bound by the bench
`timescale 1ns/1ps
module pio_ports_props #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [5:0] first_port_bits_out,
  input wire logic [5:0] first_port_bits_oe_n,
  input wire logic [5:0] first_port_pulldown_en,
  input wire logic [7:0] second_port_bits_out,
  input wire logic [7:0] second_port_bits_oe_n,
  input wire logic [7:0] third_port_direction,
  input wire logic [7:0] third_port_pulldown_en,
  input wire logic ext_irq_pin_n,
  input wire logic ext_irq_request
);
  logic [ADDR_W-1:0] idx;
  logic taken;
  logic rd;
  assign idx = avs_address >> 2;
  assign taken = avs_write && !avs_waitrequest;
  assign rd = avs_read && !avs_waitrequest;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_inputs: assert property (
    $rose(rst_n) |-> first_port_bits_oe_n == 6'h3F &&
      second_port_bits_oe_n == 8'hFF && first_port_pulldown_en == 6'h3F
  ) else $error("pins not inputs with pull-downs after reset");
  a_out_pull_off: assert property (
    (first_port_pulldown_en & ~first_port_bits_oe_n) == 6'h00
  ) else $error("pull-down on while pin drives");
  a_c_pull_inputs: assert property (
    (third_port_pulldown_en & third_port_direction) == 8'h00
  ) else $error("port c pull-down on an output");
  a_latch_write_only: assert property (
    $changed(first_port_bits_out[3:0]) |-> $past(taken)
  ) else $error("port a latch moved without a write");
  a_b_latch_kept: assert property (
    $changed(second_port_bits_out) |-> $past(taken)
  ) else $error("port b latch moved without a write");
  a_dir_write_only: assert property (
    $changed({first_port_bits_oe_n, second_port_bits_oe_n}) |-> $past(taken)
  ) else $error("direction moved without a write");
  a_upper_zero: assert property (
    rd && (idx == ADDR_W'(pio_pkg::FIRST_PORT_DATA_IDX) ||
      idx == ADDR_W'(pio_pkg::FIRST_PORT_DIRECTION_IDX)) |->
      avs_readdata[7:6] == 2'h0
  ) else $error("port a upper bits not zero");
  a_inhibit_reads_zero: assert property (
    rd && idx == ADDR_W'(pio_pkg::PULLDOWN_INHIBIT_A_C_IDX) |->
      avs_readdata == 32'h0
  ) else $error("write-only register read nonzero");
  a_irq_on_fall: assert property (
    $fell(ext_irq_pin_n) |-> ##[1:5] ext_irq_request
  ) else $error("no request after dedicated pin fell");
  c_irq: cover property (ext_irq_request);
  c_read_done: cover property (rd);
  c_all_out: cover property (first_port_bits_oe_n == 6'h00);
endmodule : pio_ports_props
